// ---- src/rbrd_defines.svh ----
// Register offsets, field positions and constants of the receive ring DMA
// Overview of operation
// - The two-byte length field is stored untouched and never steers any decision.
// - No padding is stripped or added, and oversize data fields are never flagged.
// - Transmit appends a 32-bit Ethernet CRC as the frame check sequence.
// - Receive runs every byte through the CRC; only the fixed residue passes.
// - Transmit fetches from buffer memory and retries after collisions, at most 15 times.
// - Remote channel moves data port bytes to and from memory only in I/O mode.
// - The ring is contiguous 256-byte pages bounded by first and end page registers.
// - Both ring bound registers are eight bits and select 256-byte pages in 64 kbytes.
// - Write page holds the frame's first page and is the rollback point.
// - Read page marks the oldest unread frame, seeds the remote channel, host advances it.
// - A frame starts at the write page, four bytes in, leaving room for status.
// - A full page links forward to the next contiguous page; none are skipped.
// - A next page equal to the ring end page is replaced by the first page.
// - A next page equal to the read page aborts the frame.
// - Only a next page matching neither is linked and written.
`ifndef RBRD_DEFINES_SVH
`define RBRD_DEFINES_SVH

`define RBRD_REG_CTRL        8'h00
`define RBRD_REG_RING_FIRST  8'h04
`define RBRD_REG_RING_END    8'h08
`define RBRD_REG_WRITE_PAGE  8'h0c
`define RBRD_REG_READ_PAGE   8'h10
`define RBRD_REG_STATUS      8'h14
`define RBRD_REG_MASK        8'h18
`define RBRD_REG_LOCAL_ADDR  8'h1c
`define RBRD_REG_TX_PAGE     8'h20
`define RBRD_REG_TX_COUNT    8'h24
`define RBRD_REG_CMD         8'h28
`define RBRD_REG_REM_ADDR    8'h2c
`define RBRD_REG_REM_COUNT   8'h30
`define RBRD_REG_DATA_PORT   8'h34

`define RBRD_CTRL_RX_EN      0
`define RBRD_CTRL_IO_MODE    1
`define RBRD_CMD_TX_GO       0
`define RBRD_CMD_SEED        1

`define RBRD_EV_RX_OK        0
`define RBRD_EV_RX_CRC       1
`define RBRD_EV_RX_ABORT     2
`define RBRD_EV_TX_DONE      3
`define RBRD_EV_TX_ABORT     4
`define RBRD_EV_REM_DONE     5
`define RBRD_EV_W            6

`define RBRD_RX_HDR          8'h04
`define RBRD_MAX_RETRY       4'hf
`define RBRD_CRC_INIT        32'hffffffff
`define RBRD_CRC_POLY        32'hedb88320
`define RBRD_CRC_RESIDUE     32'hdebb20e3

`endif

// ---- src/rbrd_pkg.sv ----
// Types of the receive ring DMA: state record and port carriers
package rbrd_pkg;

   typedef enum logic [1:0] {RX_IDLE, RX_STORE, RX_DROP} rbrd_rx_st_t;
   typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_FCS} rbrd_tx_st_t;

   typedef struct packed {
      logic       valid;
      logic       sof;
      logic       eof;
      logic [7:0] data;
   } rbrd_byte_t;

   typedef struct packed {
      logic        we;
      logic        re;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } rbrd_mem_req_t;

   typedef struct packed {
      logic        rx_en;
      logic        io_mode;
      logic [7:0]  ring_first;
      logic [7:0]  ring_end;
      logic [7:0]  write_page;
      logic [7:0]  read_page;
      logic [5:0]  status;
      logic [5:0]  mask;
      logic [7:0]  tx_page;
      logic [15:0] tx_count;
      logic [15:0] rem_addr;
      logic [15:0] rem_count;
      rbrd_rx_st_t rx_st;
      logic [15:0] rx_addr;
      logic [31:0] rx_crc;
      rbrd_tx_st_t tx_st;
      logic [15:0] tx_addr;
      logic [15:0] tx_left;
      logic [7:0]  tx_hold;
      logic        tx_full;
      logic        tx_pend;
      logic [31:0] tx_crc;
      logic [1:0]  tx_idx;
      logic [3:0]  tx_tries;
      logic        ph_valid;
      logic        ph_write;
      logic [7:0]  ph_addr;
      logic        ph_done;
      logic        rem_wait;
      logic [31:0] hrdata;
   } rbrd_state_t;

endpackage : rbrd_pkg

// ---- src/rbrd_top.sv ----
// Receive ring DMA with transmit fetch, remote channel and AHB-Lite register slave
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "rbrd_defines.svh"

module rbrd_top (
   // Clock and reset
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   // AHB-Lite slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic [31:0]                 hrdata,
   // Receive byte stream from the MAC
   input  wire rbrd_pkg::rbrd_byte_t   rx_in,
   output logic                        rx_ready,
   // Transmit byte stream to the MAC
   output rbrd_pkg::rbrd_byte_t        tx_out,
   input  wire logic                   tx_ready,
   input  wire logic                   tx_col,
   // Buffer memory, read data one cycle after the request
   output rbrd_pkg::rbrd_mem_req_t     mem_req,
   input  wire logic [7:0]             mem_rdata,
   // Interrupt
   output logic                        irq
);

   rbrd_pkg::rbrd_state_t s_r;
   rbrd_pkg::rbrd_state_t s_nxt;

   // Reflected CRC-32, one byte, low bit first
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[0] ^ d[i]) begin
            r = (r >> 1) ^ `RBRD_CRC_POLY;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction : crc_byte

   // Page following p, folded back to the ring start at the ring end
   function automatic logic [7:0] page_after(input logic [7:0] p, input logic [7:0] first,
                                             input logic [7:0] last);
      logic [7:0] n;
      n = p + 8'h01;
      if (n == last) begin
         n = first;
      end
      return n;
   endfunction : page_after

   logic                rx_take;
   logic [15:0]         rx_wa;
   logic [31:0]         rx_c;
   logic [7:0]          rx_np;
   logic                rx_pg_last;
   logic                tx_issue;
   logic                rem_req;
   logic                rem_grant;
   logic                dp;
   logic [5:0]          ev;
   logic [5:0]          clr;
   logic [31:0]         fcs;
   logic [31:0]         rd_val;

   assign dp        = s_r.ph_valid && (s_r.ph_addr == `RBRD_REG_DATA_PORT)
                      && s_r.io_mode && (s_r.rem_count != 16'h0000);
   // Ordinary writes finish at once; reads and data port moves wait for ph_done
   assign hreadyout = !s_r.ph_valid || (s_r.ph_write && !dp) || s_r.ph_done;
   assign hresp     = 1'b0;
   assign hrdata    = s_r.hrdata;
   assign rx_ready  = 1'b1;
   assign irq       = |(s_r.status & s_r.mask);
   assign fcs       = ~s_r.tx_crc;

   always_comb begin
      s_nxt     = s_r;
      ev        = '0;
      clr       = '0;
      rd_val    = '0;
      mem_req   = '0;
      tx_out    = '0;
      rem_req   = 1'b0;
      rem_grant = 1'b0;

      // Receive: bytes, length and pad included, go to memory as they come
      case (s_r.rx_st)
         rbrd_pkg::RX_IDLE: begin
            rx_take = rx_in.valid && rx_in.sof && s_r.rx_en;
         end
         rbrd_pkg::RX_STORE: begin
            // A fresh start of frame restarts the store at the write page
            rx_take = rx_in.valid && (s_r.rx_en || !rx_in.sof);
         end
         rbrd_pkg::RX_DROP: begin
            rx_take = rx_in.valid && rx_in.sof && s_r.rx_en;
            if (rx_in.valid && rx_in.eof && !rx_take) begin
               s_nxt.rx_st = rbrd_pkg::RX_IDLE;
            end
         end
         default: begin
            rx_take = 1'b0;
         end
      endcase
      if (rx_in.sof) begin
         rx_wa = {s_r.write_page, `RBRD_RX_HDR};
         rx_c  = crc_byte(`RBRD_CRC_INIT, rx_in.data);
      end else begin
         rx_wa = s_r.rx_addr;
         rx_c  = crc_byte(s_r.rx_crc, rx_in.data);
      end
      rx_np      = page_after(rx_wa[15:8], s_r.ring_first, s_r.ring_end);
      rx_pg_last = (rx_wa[7:0] == 8'hff);
      if (rx_take) begin
         mem_req.we    = 1'b1;
         mem_req.addr  = rx_wa;
         mem_req.wdata = rx_in.data;
         s_nxt.rx_crc  = rx_c;
         s_nxt.rx_addr = rx_wa + 16'h0001;
         s_nxt.rx_st   = rbrd_pkg::RX_STORE;
         if (rx_pg_last && rx_np == s_r.read_page) begin
            // Next page is still unread: give up the frame, write page stays
            if (rx_in.eof) begin
               s_nxt.rx_st = rbrd_pkg::RX_IDLE;
            end else begin
               s_nxt.rx_st = rbrd_pkg::RX_DROP;
            end
            ev[`RBRD_EV_RX_ABORT] = 1'b1;
         end else begin
            if (rx_pg_last) begin
               s_nxt.rx_addr = {rx_np, 8'h00};
            end
            if (rx_in.eof) begin
               s_nxt.rx_st = rbrd_pkg::RX_IDLE;
               if (rx_c == `RBRD_CRC_RESIDUE) begin
                  s_nxt.write_page = rx_np;
                  ev[`RBRD_EV_RX_OK] = 1'b1;
               end else begin
                  // Bad frame: pages are reclaimed by leaving the write page alone
                  ev[`RBRD_EV_RX_CRC] = 1'b1;
               end
            end
         end
      end

      // Transmit fetch, one byte in flight, receive has the memory first
      tx_issue = (s_r.tx_st == rbrd_pkg::TX_DATA) && !s_r.tx_full && !s_r.tx_pend
                 && (s_r.tx_left != 16'h0000) && !rx_take;
      if (s_r.tx_pend) begin
         s_nxt.tx_hold = mem_rdata;
         s_nxt.tx_full = 1'b1;
         s_nxt.tx_pend = 1'b0;
      end
      if (tx_issue) begin
         mem_req.re    = 1'b1;
         mem_req.addr  = s_r.tx_addr;
         s_nxt.tx_addr = s_r.tx_addr + 16'h0001;
         s_nxt.tx_left = s_r.tx_left - 16'h0001;
         s_nxt.tx_pend = 1'b1;
      end
      case (s_r.tx_st)
         rbrd_pkg::TX_DATA: begin
            tx_out.valid = s_r.tx_full;
            tx_out.data  = s_r.tx_hold;
            if (s_r.tx_full && tx_ready) begin
               s_nxt.tx_full = 1'b0;
               s_nxt.tx_crc  = crc_byte(s_r.tx_crc, s_r.tx_hold);
            end
            if (s_r.tx_left == 16'h0000 && !s_r.tx_full && !s_r.tx_pend) begin
               s_nxt.tx_st  = rbrd_pkg::TX_FCS;
               s_nxt.tx_idx = 2'd0;
            end
         end
         rbrd_pkg::TX_FCS: begin
            tx_out.valid = 1'b1;
            tx_out.data  = fcs[{s_r.tx_idx, 3'b000} +: 8];
            tx_out.eof   = (s_r.tx_idx == 2'd3);
            if (tx_ready) begin
               s_nxt.tx_idx = s_r.tx_idx + 2'd1;
               if (s_r.tx_idx == 2'd3) begin
                  s_nxt.tx_st = rbrd_pkg::TX_IDLE;
                  ev[`RBRD_EV_TX_DONE] = 1'b1;
               end
            end
         end
         default: begin
         end
      endcase
      if (tx_col && s_r.tx_st != rbrd_pkg::TX_IDLE) begin
         if (s_r.tx_tries == `RBRD_MAX_RETRY) begin
            s_nxt.tx_st = rbrd_pkg::TX_IDLE;
            ev[`RBRD_EV_TX_ABORT] = 1'b1;
         end else begin
            // Restart from the first byte; a fetch still in flight is dropped
            s_nxt.tx_tries = s_r.tx_tries + 4'h1;
            s_nxt.tx_st    = rbrd_pkg::TX_DATA;
            s_nxt.tx_addr  = {s_r.tx_page, 8'h00};
            s_nxt.tx_left  = s_r.tx_count;
            s_nxt.tx_full  = 1'b0;
            s_nxt.tx_pend  = 1'b0;
            s_nxt.tx_crc   = `RBRD_CRC_INIT;
         end
      end

      // Remote channel through the data port, lowest memory priority
      rem_req   = dp && !s_r.ph_done && !s_r.rem_wait;
      rem_grant = rem_req && !rx_take && !tx_issue;
      if (rem_grant) begin
         mem_req.addr = s_r.rem_addr;
         if (s_r.ph_write) begin
            mem_req.we      = 1'b1;
            mem_req.wdata   = hwdata[7:0];
            s_nxt.ph_done   = 1'b1;
            s_nxt.rem_addr  = s_r.rem_addr + 16'h0001;
            s_nxt.rem_count = s_r.rem_count - 16'h0001;
            ev[`RBRD_EV_REM_DONE] = (s_r.rem_count == 16'h0001);
         end else begin
            mem_req.re     = 1'b1;
            s_nxt.rem_wait = 1'b1;
         end
      end
      // Memory answers a cycle later; the bus keeps waiting until then
      if (s_r.rem_wait) begin
         s_nxt.hrdata    = {24'h000000, mem_rdata};
         s_nxt.rem_wait  = 1'b0;
         s_nxt.ph_done   = 1'b1;
         s_nxt.rem_addr  = s_r.rem_addr + 16'h0001;
         s_nxt.rem_count = s_r.rem_count - 16'h0001;
         ev[`RBRD_EV_REM_DONE] = (s_r.rem_count == 16'h0001);
      end

      // Register reads: one wait state, value taken in the data phase
      case (s_r.ph_addr)
         `RBRD_REG_CTRL: begin
            rd_val = {30'h0, s_r.io_mode, s_r.rx_en};
         end
         `RBRD_REG_RING_FIRST: begin
            rd_val = {24'h0, s_r.ring_first};
         end
         `RBRD_REG_RING_END: begin
            rd_val = {24'h0, s_r.ring_end};
         end
         `RBRD_REG_WRITE_PAGE: begin
            rd_val = {24'h0, s_r.write_page};
         end
         `RBRD_REG_READ_PAGE: begin
            rd_val = {24'h0, s_r.read_page};
         end
         `RBRD_REG_STATUS: begin
            rd_val = {26'h0, s_r.status};
         end
         `RBRD_REG_MASK: begin
            rd_val = {26'h0, s_r.mask};
         end
         `RBRD_REG_LOCAL_ADDR: begin
            rd_val = {16'h0, s_r.rx_addr};
         end
         `RBRD_REG_TX_PAGE: begin
            rd_val = {24'h0, s_r.tx_page};
         end
         `RBRD_REG_TX_COUNT: begin
            rd_val = {16'h0, s_r.tx_count};
         end
         `RBRD_REG_CMD: begin
            rd_val = {30'h0, s_r.rx_st != rbrd_pkg::RX_IDLE,
                      s_r.tx_st != rbrd_pkg::TX_IDLE};
         end
         `RBRD_REG_REM_ADDR: begin
            rd_val = {16'h0, s_r.rem_addr};
         end
         `RBRD_REG_REM_COUNT: begin
            rd_val = {16'h0, s_r.rem_count};
         end
         default: begin
            // Unmapped offsets read as zero
            rd_val = 32'h00000000;
         end
      endcase
      if (s_r.ph_valid && !s_r.ph_write && !dp && !s_r.ph_done) begin
         s_nxt.hrdata  = rd_val;
         s_nxt.ph_done = 1'b1;
      end

      // Register writes, applied in the single data phase cycle
      if (s_r.ph_valid && s_r.ph_write && !dp) begin
         case (s_r.ph_addr)
            `RBRD_REG_CTRL: begin
               s_nxt.rx_en   = hwdata[`RBRD_CTRL_RX_EN];
               s_nxt.io_mode = hwdata[`RBRD_CTRL_IO_MODE];
            end
            `RBRD_REG_RING_FIRST: begin
               s_nxt.ring_first = hwdata[7:0];
            end
            `RBRD_REG_RING_END: begin
               s_nxt.ring_end = hwdata[7:0];
            end
            `RBRD_REG_WRITE_PAGE: begin
               s_nxt.write_page = hwdata[7:0];
            end
            `RBRD_REG_READ_PAGE: begin
               s_nxt.read_page = hwdata[7:0];
            end
            `RBRD_REG_STATUS: begin
               // Ones clear status bits, zeros leave them
               clr = hwdata[5:0];
            end
            `RBRD_REG_MASK: begin
               s_nxt.mask = hwdata[5:0];
            end
            `RBRD_REG_TX_PAGE: begin
               s_nxt.tx_page = hwdata[7:0];
            end
            `RBRD_REG_TX_COUNT: begin
               s_nxt.tx_count = hwdata[15:0];
            end
            `RBRD_REG_REM_ADDR: begin
               s_nxt.rem_addr = hwdata[15:0];
            end
            `RBRD_REG_REM_COUNT: begin
               s_nxt.rem_count = hwdata[15:0];
            end
            `RBRD_REG_CMD: begin
               if (hwdata[`RBRD_CMD_SEED]) begin
                  s_nxt.rem_addr = {s_r.read_page, 8'h00};
               end
               if (hwdata[`RBRD_CMD_TX_GO] && s_r.tx_st == rbrd_pkg::TX_IDLE
                   && s_r.tx_count != 16'h0000) begin
                  s_nxt.tx_st    = rbrd_pkg::TX_DATA;
                  s_nxt.tx_addr  = {s_r.tx_page, 8'h00};
                  s_nxt.tx_left  = s_r.tx_count;
                  s_nxt.tx_full  = 1'b0;
                  s_nxt.tx_pend  = 1'b0;
                  s_nxt.tx_tries = 4'h0;
                  s_nxt.tx_crc   = `RBRD_CRC_INIT;
               end
            end
            default: begin
            end
         endcase
      end

      // Sticky events: a new event outweighs a clear in the same cycle
      s_nxt.status = (s_r.status & ~clr) | ev;

      // Address phase capture
      if (hready) begin
         s_nxt.ph_valid = hsel && htrans[1];
         s_nxt.ph_write = hwrite;
         s_nxt.ph_addr  = haddr[7:0];
         s_nxt.ph_done  = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule : rbrd_top
`default_nettype wire

// ---- verification/rbrd_top_properties.sv ----
// Concurrent port checks for the receive ring DMA
`timescale 1ns/10ps
`default_nettype none
module rbrd_top_properties (
   // Clock and reset
   input wire logic                    hclk,
   input wire logic                    hresetn,
   // Register bus
   input wire logic                    hsel,
   input wire logic [31:0]             haddr,
   input wire logic [1:0]              htrans,
   input wire logic                    hwrite,
   input wire logic                    hready,
   input wire logic                    hreadyout,
   input wire logic                    hresp,
   // Streams and memory
   input wire rbrd_pkg::rbrd_byte_t    rx_in,
   input wire rbrd_pkg::rbrd_byte_t    tx_out,
   input wire logic                    tx_ready,
   input wire logic                    tx_col,
   input wire rbrd_pkg::rbrd_mem_req_t mem_req
);
   logic [15:0] wa_r;
   logic [15:0] wa_nxt;
   logic        take;
   // Ordinary registers only; the data port may stretch its wait
   assign take = hsel & htrans[1] & hready & (haddr[7:0] < 8'h34);
   always_comb wa_nxt = (rx_in.valid & mem_req.we) ? mem_req.addr : wa_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         wa_r <= 16'h0000;
      else
         wa_r <= wa_nxt;
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not OKAY");
   chk_write_nowait: assert property (take & hwrite |=> hreadyout)
      else $error("write data phase stretched");
   chk_read_onewait: assert property (take & !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state count wrong");
   chk_sof_offset: assert property (
      rx_in.valid & rx_in.sof & mem_req.we |-> mem_req.addr[7:0] == 8'h04)
      else $error("first byte not at page offset 4");
   chk_byte_pass: assert property (rx_in.valid & mem_req.we |-> mem_req.wdata == rx_in.data)
      else $error("stored byte differs from received byte");
   chk_addr_step: assert property (
      rx_in.valid & !rx_in.sof & mem_req.we & (wa_r[7:0] != 8'hff)
      |-> mem_req.addr == wa_r + 16'h0001)
      else $error("receive address not contiguous");
   chk_page_link: assert property (
      rx_in.valid & !rx_in.sof & mem_req.we & (wa_r[7:0] == 8'hff)
      |-> mem_req.addr[7:0] == 8'h00 && mem_req.addr[15:8] != wa_r[15:8])
      else $error("page link not at page boundary");
   chk_tx_hold: assert property (
      tx_out.valid & !tx_ready & !tx_col |=> tx_out.valid && $stable(tx_out.data))
      else $error("transmit byte dropped while stalled");
endmodule : rbrd_top_properties
bind rbrd_top rbrd_top_properties chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hreadyout, .hresp, .rx_in, .tx_out, .tx_ready, .tx_col, .mem_req);
`default_nettype wire

// ---- verification/rbrd_mem_model.sv ----
// Buffer memory partner: byte RAM with read data one cycle after the request
`timescale 1ns/10ps
`default_nettype none
module rbrd_mem_model (
   // Clock and request
   input wire logic                    hclk,
   input wire rbrd_pkg::rbrd_mem_req_t mem_req,
   // Read data
   output logic [7:0]                  mem_rdata
);
   logic [7:0] mem [0:65535];
   initial mem_rdata = 8'h00;
   // Idle cycles show the inverted last value so stale data cannot pass
   always @(posedge hclk) begin
      if (mem_req.we)
         mem[mem_req.addr] <= mem_req.wdata;
      mem_rdata <= mem_req.re ? mem[mem_req.addr] : ~mem_rdata;
   end
endmodule : rbrd_mem_model
`default_nettype wire

// ---- verification/tb_rbrd_top.sv ----
// Self-checking bench for the receive ring DMA
`timescale 1ns/10ps
`default_nettype none
`include "rbrd_defines.svh"
module tb_rbrd_top;
   logic                    hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_ready;
   logic                    tx_ready, tx_col, irq;
   logic [1:0]              htrans;
   logic [31:0]             haddr, hwdata, hrdata, rd;
   logic [7:0]              mem_rdata;
   rbrd_pkg::rbrd_byte_t    rx_in, tx_out;
   rbrd_pkg::rbrd_mem_req_t mem_req;
   logic [7:0]              frm[$];
   logic [7:0]              got[$];
   int                      n_mismatch = 0;
   int                      samples_checked = 0;

   rbrd_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_in, .rx_ready, .tx_out, .tx_ready,
      .tx_col, .mem_req, .mem_rdata, .irq);
   rbrd_mem_model mem_u (.hclk, .mem_req, .mem_rdata);

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   task stop_test;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   task tmo;
      $display("[ERR] %0t timeout", $time);
      n_mismatch++;
      stop_test();
   endtask : tmo
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (n >= 100)
         tmo();
   endtask : wait_rdy
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h000000, a};
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rchk
   // Length field claims five bytes whatever the real size
   function automatic logic [7:0] pat(input int i);
      return (i == 12) ? 8'h00 : (i == 13) ? 8'h05 : 8'(i * 3 + 1);
   endfunction : pat
   task build(input int n, input logic bad);
      logic [31:0] c;
      frm.delete();
      c = `RBRD_CRC_INIT;
      for (int i = 0; i < n; i++) begin
         frm.push_back(pat(i));
         c = c ^ {24'h000000, pat(i)};
         for (int k = 0; k < 8; k++)
            c = c[0] ? (c >> 1) ^ `RBRD_CRC_POLY : c >> 1;
      end
      c = ~c;
      for (int k = 0; k < 4; k++)
         frm.push_back(c[8*k +: 8] ^ {7'h00, bad});
   endtask : build
   task send;
      foreach (frm[i]) begin
         @(posedge hclk);
         rx_in <= '{1'b1, i == 0, i == frm.size() - 1, frm[i]};
      end
      @(posedge hclk);
      rx_in <= '0;
      repeat (2) @(posedge hclk);
   endtask : send
   // Expected location of each byte, wrapping at ring end 48h back to 40h
   task mchk(input logic [7:0] wp, input int upto);
      int         off;
      logic [7:0] pg;
      for (int i = 0; i < upto; i++) begin
         off = 4 + i;
         pg = wp + 8'(off / 256);
         if (pg >= 8'h48)
            pg = pg - 8'h08;
         chk({24'h0, mem_u.mem[{pg, 8'(off)}]}, {24'h0, frm[i]});
      end
   endtask : mchk
   task tx_try(input logic col);
      int t;
      got.delete();
      for (t = 0; t < 400 && got.size() < (col ? 1 : frm.size()); t++) begin
         @(posedge hclk);
         tx_ready <= ~tx_ready;
         if (tx_out.valid === 1'b1 && tx_ready === 1'b1) begin
            got.push_back(tx_out.data);
            if (got.size() == frm.size())
               chk({31'h0, tx_out.eof}, 32'h1);
         end
      end
      if (t >= 400)
         tmo();
      if (col) begin
         tx_col <= 1'b1;
         @(posedge hclk);
         tx_col <= 1'b0;
      end
   endtask : tx_try

   initial begin
      {hsel, hwrite, tx_ready, tx_col, htrans, haddr, hwdata} = '0;
      rx_in = '0;
      hresetn = 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rchk(`RBRD_REG_RING_FIRST, 32'h0);
      wr(8'h3c, 32'hffffffff);
      rchk(8'h3c, 32'h0);
      wr(`RBRD_REG_RING_FIRST, 32'h40);
      wr(`RBRD_REG_RING_END, 32'h48);
      wr(`RBRD_REG_WRITE_PAGE, 32'h40);
      wr(`RBRD_REG_READ_PAGE, 32'h40);
      rchk(`RBRD_REG_RING_END, 32'h48);
      wr(`RBRD_REG_CTRL, 32'h1);
      build(1520, 1'b0);
      send();
      mchk(8'h40, 1524);
      rchk(`RBRD_REG_WRITE_PAGE, 32'h46);
      rchk(`RBRD_REG_STATUS, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(`RBRD_REG_MASK, 32'h3f);
      rchk(`RBRD_REG_MASK, 32'h3f);
      chk({31'h0, irq}, 32'h1);
      wr(`RBRD_REG_STATUS, 32'h3f);
      rchk(`RBRD_REG_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      build(20, 1'b1);
      send();
      rchk(`RBRD_REG_STATUS, 32'h2);
      rchk(`RBRD_REG_WRITE_PAGE, 32'h46);
      wr(`RBRD_REG_STATUS, 32'h3f);
      wr(`RBRD_REG_READ_PAGE, 32'h41);
      build(600, 1'b0);
      send();
      mchk(8'h46, 604);
      rchk(`RBRD_REG_WRITE_PAGE, 32'h41);
      rchk(`RBRD_REG_STATUS, 32'h1);
      rchk(`RBRD_REG_LOCAL_ADDR, 32'h4060);
      wr(`RBRD_REG_STATUS, 32'h3f);
      wr(`RBRD_REG_READ_PAGE, 32'h42);
      build(300, 1'b0);
      send();
      mchk(8'h41, 252);
      chk({24'h0, mem_u.mem[16'h4200]}, {24'h0, pat(508)});
      rchk(`RBRD_REG_STATUS, 32'h4);
      rchk(`RBRD_REG_WRITE_PAGE, 32'h41);
      wr(`RBRD_REG_STATUS, 32'h3f);
      wr(`RBRD_REG_REM_COUNT, 32'h2);
      rchk(`RBRD_REG_DATA_PORT, 32'h0);
      wr(`RBRD_REG_CTRL, 32'h3);
      wr(`RBRD_REG_READ_PAGE, 32'h46);
      wr(`RBRD_REG_CMD, 32'h2);
      rchk(`RBRD_REG_REM_ADDR, 32'h4600);
      wr(`RBRD_REG_REM_ADDR, 32'h4604);
      rchk(`RBRD_REG_DATA_PORT, {24'h0, pat(0)});
      rchk(`RBRD_REG_DATA_PORT, {24'h0, pat(1)});
      rchk(`RBRD_REG_STATUS, 32'h20);
      wr(`RBRD_REG_STATUS, 32'h3f);
      for (int i = 0; i < 6; i++)
         mem_u.mem[16'h5000 + i] = pat(i);
      build(6, 1'b0);
      wr(`RBRD_REG_TX_PAGE, 32'h50);
      wr(`RBRD_REG_TX_COUNT, 32'h6);
      wr(`RBRD_REG_CMD, 32'h1);
      rchk(`RBRD_REG_CMD, 32'h1);
      repeat (15) tx_try(1'b1);
      tx_try(1'b0);
      foreach (frm[i])
         chk({24'h0, got[i]}, {24'h0, frm[i]});
      rchk(`RBRD_REG_STATUS, 32'h8);
      wr(`RBRD_REG_STATUS, 32'h3f);
      wr(`RBRD_REG_CMD, 32'h1);
      repeat (16) tx_try(1'b1);
      rchk(`RBRD_REG_STATUS, 32'h10);
      stop_test();
   end
endmodule : tb_rbrd_top
`default_nettype wire
